// ---- hw/uart_irq_baud.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_baud_defines.svh"

module uart_irq_baud
    import uart_irq_baud_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // 24 mhz reference as one-cycle enable
    input  wire logic        ref_tick,
    // axi4-lite write address
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi4-lite write response
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi4-lite read data
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // receive and transmit datapath status
    input  wire logic        rx_data_ready,
    input  wire logic        rx_trigger_reached,
    input  wire logic        rx_char_done,
    input  wire logic        tx_empty_event,
    input  wire logic        overrun_event,
    input  wire logic        parity_error_event,
    input  wire logic        missing_stop_event,
    input  wire logic        silent_break_event,
    input  wire logic [3:0]  hs_change_event,
    input  wire logic [3:0]  hs_level,
    // strobes to datapath
    output logic             rx_read_pulse,
    output logic             tx_write_pulse,
    output logic [7:0]       tx_write_data,
    input  wire logic [7:0]  rx_buffer_data,
    // baud output and interrupt pin
    output logic             baud16_tick,
    output logic             irq_out,
    output logic             irq_oe_n
);
    import uart_irq_baud_pkg::*;

    typedef struct packed {
        logic        aw_hold;
        logic [11:0] aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
        logic [3:0]  ien;
        logic [7:0]  fifo_ctrl;
        logic [4:0]  hs_ctrl;
        logic [7:0]  scratch;
        logic [7:0]  div_lo;
        logic [7:0]  div_hi;
        logic [2:0]  clk_cfg;
        logic [3:0]  line_flags;
        logic [3:0]  hs_flags;
        logic        tx_empty;
        logic        timeout;
        logic [9:0]  tick_cnt;
        logic [2:0]  char_cnt;
        logic [7:0]  pre_acc;
        logic [15:0] div_cnt;
        logic        baud;
        logic        rx_rd;
        logic        tx_wr;
        logic [7:0]  tx_data;
    } state_t;

    state_t q;
    state_t d;

    logic        wr_go;
    logic        rd_go;
    logic [11:0] wa;
    logic [7:0]  wb;
    logic        fifo_mode;
    irq_src_t    src;
    logic [3:0]  iid;
    logic        pre_tick;
    logic [7:0]  step;
    logic [7:0]  modv;
    logic [8:0]  acc_sum;
    logic [15:0] divisor;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    assign fifo_mode = q.fifo_ctrl[`UFR_FIFO_EN];
    assign divisor   = {q.div_hi, q.div_lo};

    // priority encode the enabled pending sources
    always_comb begin
        src = SRC_NONE;
        iid = `IID_NONE;
        if (q.ien[2] && |q.line_flags) begin
            src = SRC_LINE;
            iid = `IID_LINE_STATUS;
        end else if (q.ien[0] && fifo_mode && q.timeout) begin
            src = SRC_TIMEOUT;
            iid = `IID_TIMEOUT;
        end else if (q.ien[0] && (fifo_mode ? rx_trigger_reached : rx_data_ready)) begin
            src = SRC_RX;
            iid = `IID_RX_READY;
        end else if (q.ien[1] && q.tx_empty) begin
            src = SRC_TX;
            iid = `IID_TX_EMPTY;
        end else if (q.ien[3] && |q.hs_flags) begin
            src = SRC_HS;
            iid = `IID_HANDSHAKE;
        end
    end

    // pre-divider step selection
    always_comb begin
        case (prediv_t'(q.clk_cfg[1:0]))
            PREDIV_13: begin
                step = `PREDIV_13_STEP;
                modv = `PREDIV_13_MOD;
            end
            PREDIV_1625: begin
                step = `PREDIV_1625_STEP;
                modv = `PREDIV_1625_MOD;
            end
            default: begin
                step = 8'h01;
                modv = 8'h01;
            end
        endcase
    end

    assign acc_sum  = {1'b0, q.pre_acc} + {1'b0, step};
    assign pre_tick = ref_tick && (q.clk_cfg[2] || (acc_sum >= {1'b0, modv}));

    assign wr_go = q.aw_hold && q.w_hold && !q.bvalid;
    assign rd_go = arvalid && !q.rvalid;
    assign wa    = q.aw_addr;
    assign wb    = q.w_strb[0] ? q.w_data[7:0] : 8'h00;

    always_comb begin
        d = q;
        d.rx_rd = 1'b0;
        d.tx_wr = 1'b0;
        d.baud  = 1'b0;
        if (awvalid && !q.aw_hold) begin
            d.aw_hold = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && !q.w_hold) begin
            d.w_hold = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        // pre-divider accumulator advances on reference ticks and baud divider on pre-divider ticks, ahead of the access side effects
        if (ref_tick) begin
            d.pre_acc = q.clk_cfg[2] ? 8'h00 : (acc_sum >= {1'b0, modv}) ? acc_sum[7:0] - modv : acc_sum[7:0];
        end
        if (pre_tick) begin
            if (q.div_cnt <= 16'h0001) begin
                d.div_cnt = divisor;
                d.baud    = (divisor != 16'h0000);
            end else begin
                d.div_cnt = q.div_cnt - 16'h0001;
            end
        end
        // read side effects
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = 2'b00;
            d.rdata  = 32'h0000_0000;
            if (hit(araddr, `OFS_RX_TX)) begin
                d.rdata[7:0] = rx_buffer_data;
                d.rx_rd = 1'b1;
            end else if (hit(araddr, `OFS_INT_ENABLE)) begin
                d.rdata[7:0] = {4'h0, q.ien};
            end else if (hit(araddr, `OFS_INT_ID)) begin
                d.rdata[7:0] = {{2{fifo_mode}}, 2'b00, iid};
            end else if (hit(araddr, `OFS_FIFO_CONTROL)) begin
                d.rdata[7:0] = q.fifo_ctrl;
            end else if (hit(araddr, `OFS_LINE_STATUS)) begin
                d.rdata[7:0] = {3'b000, q.line_flags[3], q.line_flags[2], q.line_flags[1], q.line_flags[0],
                                rx_data_ready};
            end else if (hit(araddr, `OFS_HANDSHAKE_CTRL)) begin
                d.rdata[7:0] = {3'b000, q.hs_ctrl};
            end else if (hit(araddr, `OFS_HANDSHAKE_STAT)) begin
                d.rdata[7:0] = {hs_level, q.hs_flags};
            end else if (hit(araddr, `OFS_SCRATCH)) begin
                d.rdata[7:0] = q.scratch;
            end else if (hit(araddr, `OFS_DIVISOR_LOW)) begin
                d.rdata[7:0] = q.div_lo;
            end else if (hit(araddr, `OFS_DIVISOR_HIGH)) begin
                d.rdata[7:0] = q.div_hi;
            end else if (hit(araddr, `OFS_CLOCK_CONFIG)) begin
                d.rdata[7:0] = {5'b00000, q.clk_cfg};
            end else begin
                d.rresp = 2'b10;
            end
            if (hit(araddr, `OFS_LINE_STATUS)) begin
                d.line_flags = 4'h0;
            end
            if (hit(araddr, `OFS_HANDSHAKE_STAT)) begin
                d.hs_flags = 4'h0;
            end
            if (hit(araddr, `OFS_INT_ID) && src == SRC_TX) begin
                d.tx_empty = 1'b0;
            end
            if (hit(araddr, `OFS_RX_TX)) begin
                d.timeout  = 1'b0;
                d.tick_cnt = 10'd0;
                d.char_cnt = 3'd0;
            end
        end
        // write side effects
        if (wr_go) begin
            d.aw_hold = 1'b0;
            d.w_hold  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'b00;
            if (hit(wa, `OFS_RX_TX)) begin
                d.tx_wr    = q.w_strb[0];
                d.tx_data  = q.w_data[7:0];
                d.tx_empty = 1'b0;
            end else if (hit(wa, `OFS_INT_ENABLE)) begin
                if (q.w_strb[0]) d.ien = wb[3:0];
            end else if (hit(wa, `OFS_FIFO_CONTROL)) begin
                if (q.w_strb[0]) d.fifo_ctrl = {wb[7:6], 2'b00, wb[3], 2'b00, wb[0]};
            end else if (hit(wa, `OFS_HANDSHAKE_CTRL)) begin
                if (q.w_strb[0]) d.hs_ctrl = wb[4:0];
            end else if (hit(wa, `OFS_SCRATCH)) begin
                if (q.w_strb[0]) d.scratch = wb;
            end else if (hit(wa, `OFS_DIVISOR_LOW)) begin
                if (q.w_strb[0]) d.div_lo = wb;
            end else if (hit(wa, `OFS_DIVISOR_HIGH)) begin
                if (q.w_strb[0]) d.div_hi = wb;
            end else if (hit(wa, `OFS_CLOCK_CONFIG)) begin
                if (q.w_strb[0]) d.clk_cfg = wb[2:0];
            end else if (!hit(wa, `OFS_INT_ID) && !hit(wa, `OFS_LINE_STATUS) && !hit(wa, `OFS_HANDSHAKE_STAT)) begin
                d.bresp = 2'b10;
            end
        end
        // idle time-out counting on 16x ticks while data waits
        // a receive read is an access, so it restarts the idle count
        if (!fifo_mode || !rx_data_ready || rx_char_done || (rd_go && hit(araddr, `OFS_RX_TX))) begin
            d.tick_cnt = 10'd0;
            d.char_cnt = 3'd0;
        end else if (q.baud && !q.timeout) begin
            if (q.tick_cnt == `CHAR_TICKS - 10'd1) begin
                d.tick_cnt = 10'd0;
                d.char_cnt = q.char_cnt + 3'd1;
                if (q.char_cnt == 3'(`TIMEOUT_CHARS - 1)) d.timeout = 1'b1;
            end else begin
                d.tick_cnt = q.tick_cnt + 10'd1;
            end
        end
        // hardware sets win over same-cycle clears
        d.line_flags = d.line_flags | {silent_break_event, missing_stop_event, parity_error_event, overrun_event};
        d.hs_flags   = d.hs_flags | hs_change_event;
        if (tx_empty_event) d.tx_empty = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign awready        = !q.aw_hold;
    assign wready         = !q.w_hold;
    assign bvalid         = q.bvalid;
    assign bresp          = q.bresp;
    assign arready        = !q.rvalid;
    assign rvalid         = q.rvalid;
    assign rdata          = q.rdata;
    assign rresp          = q.rresp;
    assign rx_read_pulse  = q.rx_rd;
    assign tx_write_pulse = q.tx_wr;
    assign tx_write_data  = q.tx_data;
    assign baud16_tick    = q.baud;
    assign irq_out        = (src != SRC_NONE);
    assign irq_oe_n       = !q.hs_ctrl[`HCR_IRQ_OUT_EN];

    a_iid_upper_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && hit(araddr, `OFS_INT_ID) |=> rdata[7:6] == {2{$past(fifo_mode)}} && rdata[5:4] == 2'b00)
        else $error("identification upper bits wrong");
    a_ien_zero_top: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && hit(araddr, `OFS_INT_ENABLE) |=> rdata[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    a_line_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && hit(araddr, `OFS_LINE_STATUS) && !overrun_event && !parity_error_event
        && !missing_stop_event && !silent_break_event |=> q.line_flags == 4'h0)
        else $error("line flags not cleared");
    a_line_priority: assert property (@(posedge aclk) disable iff (!aresetn)
        q.ien[2] && |q.line_flags |-> iid == `IID_LINE_STATUS)
        else $error("line status not top priority");
    a_no_enable_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        q.ien == 4'h0 |-> !irq_out && iid == `IID_NONE)
        else $error("interrupt without enable");
    a_tx_write_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && hit(wa, `OFS_RX_TX) && !tx_empty_event |=> !q.tx_empty ##0 tx_write_pulse)
        else $error("tx empty not cleared");
    a_scratch_store: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && hit(wa, `OFS_SCRATCH) && q.w_strb[0] |=> q.scratch == $past(q.w_data[7:0]))
        else $error("scratch not stored");
    a_timeout_fifo: assert property (@(posedge aclk) disable iff (!aresetn)
        iid == `IID_TIMEOUT |-> fifo_mode && q.ien[0])
        else $error("timeout outside fifo mode");
    a_irq_oe_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !q.hs_ctrl[`HCR_IRQ_OUT_EN] |-> irq_oe_n)
        else $error("irq pin driven while disabled");
    a_irq_oe_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && hit(wa, `OFS_HANDSHAKE_CTRL) && q.w_strb[0] |=> irq_oe_n == !$past(q.w_data[`HCR_IRQ_OUT_EN]))
        else $error("irq pin enable not following control");
    a_rx_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_go && hit(araddr, `OFS_RX_TX) |=> !q.timeout && rx_read_pulse)
        else $error("receive read did not clear time-out");
endmodule
`default_nettype wire

// ---- hw/uart_irq_baud_defines.svh ----
`ifndef UART_IRQ_BAUD_DEFINES_SVH
`define UART_IRQ_BAUD_DEFINES_SVH
// register byte offsets
`define OFS_RX_TX          12'h000
`define OFS_INT_ENABLE     12'h004
`define OFS_INT_ID         12'h008
`define OFS_FIFO_CONTROL   12'h00c
`define OFS_LINE_STATUS    12'h010
`define OFS_HANDSHAKE_CTRL 12'h014
`define OFS_HANDSHAKE_STAT 12'h018
`define OFS_SCRATCH        12'h01c
`define OFS_DIVISOR_LOW    12'h020
`define OFS_DIVISOR_HIGH   12'h024
`define OFS_CLOCK_CONFIG   12'h028
// identification codes, bits 3..0
`define IID_NONE           4'h1
`define IID_LINE_STATUS    4'h6
`define IID_RX_READY       4'h4
`define IID_TIMEOUT        4'hc
`define IID_TX_EMPTY       4'h2
`define IID_HANDSHAKE      4'h0
// field positions
`define HCR_IRQ_OUT_EN     3
`define UFR_FIFO_EN        0
// reset values
`define RST_BYTE           8'h00
// timeout length in character times
`define TIMEOUT_CHARS      4
// bit times per character (start, 8 data, parity, 2 stop) times 16
`define CHAR_TICKS         10'd192
// pre-divider: 13 and 13/8 (=1.625) realised as fractional step
`define PREDIV_13_STEP     8'd8
`define PREDIV_13_MOD      8'd104
`define PREDIV_1625_STEP   8'd8
`define PREDIV_1625_MOD    8'd13
`endif

// ---- hw/uart_irq_baud_pkg.sv ----
package uart_irq_baud_pkg;
    typedef enum logic [1:0] {
        PREDIV_13,
        PREDIV_1625,
        PREDIV_1
    } prediv_t;
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LINE,
        SRC_RX,
        SRC_TIMEOUT,
        SRC_TX,
        SRC_HS
    } irq_src_t;
endpackage

// ---- test/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // clock
    input  wire logic        aclk,
    // write address and data
    output var logic [11:0]  awaddr,
    output var logic         awvalid,
    input  wire logic        awready,
    output var logic [31:0]  wdata,
    output var logic [3:0]   wstrb,
    output var logic         wvalid,
    input  wire logic        wready,
    // write response
    input  wire logic        bvalid,
    output var logic         bready,
    // read channels
    output var logic [11:0]  araddr,
    output var logic         arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var logic         rready,
    // set when the slave does not answer within 100 cycles
    output var logic         hung
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        if (n >= 100) hung <= 1'b1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
        end while (!rvalid && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- test/uart_irq_baud_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_baud_defines.svh"
module uart_irq_baud_tb_top;
    logic        aclk, aresetn, ref_tick, hung;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, hs_level;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic        rx_data_ready, rx_trigger_reached, rx_char_done;
    logic [8:0]  ev;
    logic        rx_read_pulse, tx_write_pulse, baud16_tick, irq_out, irq_oe_n;
    logic [7:0]  tx_write_data;
    int          num_errors, tests_run;
    int          tx_pulses, rx_pulses;

    host_bus_model u_host_bus_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hung(hung));
    // ev: {handshake changes, break, stop, parity, overrun, tx empty}
    uart_irq_baud u_uart_irq_baud (.aclk(aclk), .aresetn(aresetn), .ref_tick(ref_tick), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_data_ready(rx_data_ready),
        .rx_trigger_reached(rx_trigger_reached), .rx_char_done(rx_char_done), .tx_empty_event(ev[0]),
        .overrun_event(ev[1]), .parity_error_event(ev[2]), .missing_stop_event(ev[3]),
        .silent_break_event(ev[4]), .hs_change_event(ev[8:5]), .hs_level(hs_level),
        .rx_read_pulse(rx_read_pulse), .tx_write_pulse(tx_write_pulse), .tx_write_data(tx_write_data),
        .rx_buffer_data(8'h5a), .baud16_tick(baud16_tick), .irq_out(irq_out), .irq_oe_n(irq_oe_n));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge aclk) if (hung === 1'b1) begin
        num_errors++;
        close_out();
    end
    // strobes last one cycle, so count them as they pass
    always @(posedge aclk) begin
        if (tx_write_pulse === 1'b1) tx_pulses++;
        if (rx_read_pulse === 1'b1) rx_pulses++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        u_host_bus_model.rd(a, d, r);
        chk(d, e);
    endtask
    task automatic rd_x(input logic [11:0] a);
        logic [31:0] d;
        logic [1:0]  r;
        u_host_bus_model.rd(a, d, r);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_host_bus_model.wr(a, {24'h0, d});
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 9'h000;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        chk(irq_oe_n, 1'b1);
        rd_chk(`OFS_INT_ID, 32'h01);
        rd_chk(`OFS_INT_ENABLE, 32'h00);
        rd_chk(`OFS_DIVISOR_LOW, 32'h00);
        rd_chk(`OFS_DIVISOR_HIGH, 32'h00);
        wr(`OFS_SCRATCH, 8'ha5);
        rd_chk(`OFS_SCRATCH, 32'ha5);
        rd_chk(`OFS_INT_ID, 32'h01);
        wr(`OFS_INT_ENABLE, 8'hff);
        rd_chk(`OFS_INT_ENABLE, 32'h0f);
        wr(`OFS_DIVISOR_HIGH, 8'h12);
        rd_chk(`OFS_DIVISOR_HIGH, 32'h12);
        u_host_bus_model.rd(12'h0fc, d, r);
        chk({30'h0, r}, 32'h2);
        $display("t_reset done");
    endtask
    task automatic t_prio();
        wr(`OFS_INT_ENABLE, 8'h0f);
        wr(`OFS_HANDSHAKE_CTRL, 8'h08);
        pulse(9'h023);
        @(negedge aclk);
        chk(irq_out, 1'b1);
        chk(irq_oe_n, 1'b0);
        rd_chk(`OFS_INT_ID, 32'h06);
        rd_chk(`OFS_LINE_STATUS, 32'h02);
        rd_chk(`OFS_INT_ID, 32'h02);
        rd_chk(`OFS_INT_ID, 32'h00);
        rd_chk(`OFS_HANDSHAKE_STAT, 32'h01);
        rd_chk(`OFS_INT_ID, 32'h01);
        for (int i = 2; i < 9; i++) begin
            pulse(9'h001 << i);
            rd_chk(`OFS_INT_ID, (i < 5) ? 32'h06 : 32'h00);
            rd_chk((i < 5) ? `OFS_LINE_STATUS : `OFS_HANDSHAKE_STAT,
                   (i < 5) ? (32'h1 << i) : (32'h1 << (i - 5)));
            rd_chk(`OFS_INT_ID, 32'h01);
        end
        pulse(9'h001);
        wr(`OFS_RX_TX, 8'h3c);
        chk(tx_write_data, 32'h3c);
        rd_chk(`OFS_INT_ID, 32'h01);
        chk(tx_pulses, 32'h1);
        $display("t_prio done");
    endtask
    task automatic t_mask();
        wr(`OFS_INT_ENABLE, 8'h00);
        pulse(9'h023);
        @(negedge aclk);
        chk(irq_out, 1'b0);
        rd_chk(`OFS_INT_ID, 32'h01);
        wr(`OFS_INT_ENABLE, 8'h04);
        rd_chk(`OFS_INT_ID, 32'h06);
        rd_x(`OFS_LINE_STATUS);
        wr(`OFS_INT_ENABLE, 8'h02);
        rd_chk(`OFS_INT_ID, 32'h02);
        rd_chk(`OFS_INT_ID, 32'h01);
        wr(`OFS_INT_ENABLE, 8'h08);
        rd_chk(`OFS_INT_ID, 32'h00);
        rd_x(`OFS_HANDSHAKE_STAT);
        wr(`OFS_INT_ENABLE, 8'h01);
        @(posedge aclk);
        rx_data_ready <= 1'b1;
        rd_chk(`OFS_INT_ID, 32'h04);
        rx_data_ready <= 1'b0;
        rd_chk(`OFS_INT_ID, 32'h01);
        wr(`OFS_HANDSHAKE_CTRL, 8'h00);
        @(negedge aclk);
        chk(irq_oe_n, 1'b1);
        $display("t_mask done");
    endtask
    task automatic t_baud();
        logic [7:0] cfg[4] = '{8'h02, 8'h01, 8'h00, 8'h04};
        logic [7:0] dv[4] = '{8'h04, 8'h01, 8'h01, 8'h04};
        int win[4] = '{64, 26, 208, 64};
        int cnt;
        wr(`OFS_DIVISOR_HIGH, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_DIVISOR_LOW, dv[i]);
            wr(`OFS_CLOCK_CONFIG, cfg[i]);
            // the first pass waits out the long count left from the earlier divisor
            repeat ((i == 0) ? 4800 : 20) @(posedge aclk);
            cnt = 0;
            repeat (win[i]) begin
                @(posedge aclk);
                if (baud16_tick === 1'b1) cnt++;
            end
            chk(32'(cnt >= 15 && cnt <= 17), 32'h1);
        end
        $display("t_baud done");
    endtask
    task automatic t_fifo();
        int n;
        wr(`OFS_DIVISOR_LOW, 8'h01);
        wr(`OFS_CLOCK_CONFIG, 8'h02);
        wr(`OFS_FIFO_CONTROL, 8'h01);
        rd_chk(`OFS_INT_ID, 32'hc1);
        wr(`OFS_INT_ENABLE, 8'h01);
        @(posedge aclk);
        rx_trigger_reached <= 1'b1;
        rd_chk(`OFS_INT_ID, 32'hc4);
        rx_trigger_reached <= 1'b0;
        rd_chk(`OFS_INT_ID, 32'hc1);
        rx_data_ready <= 1'b1;
        @(posedge aclk);
        rx_char_done <= 1'b1;
        @(posedge aclk);
        rx_char_done <= 1'b0;
        repeat (650) @(posedge aclk);
        chk(irq_out, 1'b0);
        n = 0;
        while (irq_out !== 1'b1 && n < 1500) begin
            @(posedge aclk);
            n++;
        end
        chk(32'(n < 1500), 32'h1);
        rd_chk(`OFS_INT_ID, 32'hcc);
        rd_chk(`OFS_RX_TX, 32'h5a);
        rd_chk(`OFS_INT_ID, 32'hc1);
        chk(rx_pulses, 32'h1);
        wr(`OFS_FIFO_CONTROL, 8'h00);
        rd_chk(`OFS_INT_ID, 32'h04);
        rx_data_ready <= 1'b0;
        $display("t_fifo done");
    endtask

    initial begin
        num_errors = 0;
        tests_run = 0;
        aresetn = 1'b0;
        ref_tick = 1'b1;
        rx_data_ready = 1'b0;
        rx_trigger_reached = 1'b0;
        rx_char_done = 1'b0;
        ev = 9'h000;
        hs_level = 4'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_prio();
        t_mask();
        t_baud();
        t_fifo();
        close_out();
    end
endmodule
`default_nettype wire
